/* verilog/rfcfg_consts.svh */
`ifndef RFCFG_CONSTS_SVH
`define RFCFG_CONSTS_SVH

// Register byte addresses
`define RFCFG_OFS_BASE_WORD_A_HIGH   16'hdf09
`define RFCFG_OFS_BASE_WORD_A_MID    16'hdf0a
`define RFCFG_OFS_BASE_WORD_A_LOW    16'hdf0b
`define RFCFG_OFS_BW_RATE_EXP 16'hdf0c
`define RFCFG_OFS_RATE_MANT   16'hdf0d
`define RFCFG_OFS_FORMAT_CTRL 16'hdf0e

// Reset values
`define RFCFG_RST_BASE_WORD_A_TOP    2'h1
`define RFCFG_RST_BASE_WORD_A_HIGH   6'h1e
`define RFCFG_RST_BASE_WORD_A_MID    8'hc4
`define RFCFG_RST_BASE_WORD_A_LOW    8'hec
`define RFCFG_RST_BW_EXP      2'h2
`define RFCFG_RST_BW_MANT     2'h0
`define RFCFG_RST_RATE_EXP    4'hc
`define RFCFG_RST_RATE_MANT   8'h22
`define RFCFG_RST_DC_BYPASS   1'h0
`define RFCFG_RST_MOD_SEL     3'h0

// Field positions
`define RFCFG_FLD_BASE_WORD_A_TOP_HI 7
`define RFCFG_FLD_BASE_WORD_A_TOP_LO 6
`define RFCFG_FLD_BASE_WORD_A_HI_HI  5
`define RFCFG_FLD_BW_EXP_HI   7
`define RFCFG_FLD_BW_EXP_LO   6
`define RFCFG_FLD_BW_MANT_HI  5
`define RFCFG_FLD_BW_MANT_LO  4
`define RFCFG_FLD_RATE_EXP_HI 3
`define RFCFG_FLD_DC_BYPASS   7
`define RFCFG_FLD_MOD_HI      6
`define RFCFG_FLD_MOD_LO      4

// Arithmetic constants
`define RFCFG_BW_MANT_BIAS    9'h004
`define RFCFG_BW_PRESCALE     3
`define RFCFG_RATE_HIDDEN_ONE 9'h100
`define RFCFG_RATE_FRAC_BITS  28
`define RFCFG_BYPASS_MAX_BAUD 100000

`endif

/* verilog/rfcfg_pkg.sv */
`default_nettype none
package rfcfg_pkg;

   typedef logic [15:0] rfcfg_addr_t;
   typedef logic [7:0]  rfcfg_byte_t;

   // Register selected by an address
   typedef enum logic [2:0]
   {
      RFCFG_SEL_NONE   = 3'h0,
      RFCFG_SEL_FHIGH  = 3'h1,
      RFCFG_SEL_FMID   = 3'h2,
      RFCFG_SEL_FLOW   = 3'h3,
      RFCFG_SEL_BWEXP  = 3'h4,
      RFCFG_SEL_RMANT  = 3'h5,
      RFCFG_SEL_FORMAT = 3'h6
   } rfcfg_sel_e;

   // Modulation codes known to this bank
   typedef enum logic [2:0]
   {
      RFCFG_MOD_2FSK = 3'h0,
      RFCFG_MOD_GFSK = 3'h1,
      RFCFG_MOD_RSV2 = 3'h2,
      RFCFG_MOD_RSV3 = 3'h3
   } rfcfg_mod_e;

endpackage : rfcfg_pkg
`default_nettype wire

/* verilog/rfcfg_rate_calc.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rfcfg_consts.svh"
module rfcfg_rate_calc
   import rfcfg_pkg::*;
#(
   parameter longint REF_BASE_WORD_A_HZ = 64'h18cba80
)
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [1:0]  bw_exp,
   input  wire logic [1:0]  bw_mant,
   input  wire logic [3:0]  rate_exp,
   input  wire logic [7:0]  rate_mant,
   output var  logic [8:0]  decim_div,
   output var  logic [23:0] rate_step,
   output var  logic        rate_high
);

   // Largest rate word still at or below the bypass limit
   localparam longint BYPASS_WORD =
      (64'(`RFCFG_BYPASS_MAX_BAUD) << `RFCFG_RATE_FRAC_BITS) / REF_BASE_WORD_A_HZ;

   logic [8:0]  div_next;
   logic [23:0] div_wide;
   logic [23:0] step_next;

   // Shift a 9-bit value left by an exponent, into 24 bits
   function automatic logic [23:0] rfcfg_scale(input logic [8:0] v,
                                               input logic [3:0] e);
      rfcfg_scale = {15'h0000, v} << e;
   endfunction : rfcfg_scale

   // Divider: 8 * (4 + mantissa) * 2^exponent
   always_comb
   begin
      div_wide = rfcfg_scale(9'({7'h00, bw_mant} + `RFCFG_BW_MANT_BIAS),
                             4'({2'h0, bw_exp} + 4'(`RFCFG_BW_PRESCALE)));
      div_next = div_wide[8:0];
   end

   // Step: (256 + mantissa) * 2^exponent, hidden one restored
   always_comb
   begin
      step_next = rfcfg_scale({1'b0, rate_mant} | `RFCFG_RATE_HIDDEN_ONE,
                              rate_exp);
   end

   // Registered so the datapath sees glitch-free values
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         decim_div <= 9'h000;
         rate_step <= 24'h000000;
         rate_high <= 1'b0;
      end
      else
      begin
         decim_div <= div_next;
         rate_step <= step_next;
         rate_high <= (64'(step_next) > BYPASS_WORD);
      end
   end

endmodule : rfcfg_rate_calc
`default_nettype wire

/* verilog/rfcfg_regs.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rfcfg_consts.svh"
module rfcfg_regs
   import rfcfg_pkg::*;
#(
   parameter longint REF_BASE_WORD_A_HZ = 64'h18cba80
)
(
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   input  wire logic [15:0] ADDR,
   input  wire logic [7:0]  WDATA,
   input  wire logic        WR_STB,
   input  wire logic        RD_STB,
   output var  logic [7:0]  RDATA,
   output var  logic [23:0] BASE_WORD_A,
   output var  logic [1:0]  BW_EXPONENT,
   output var  logic [1:0]  BW_MANTISSA,
   output var  logic [8:0]  BW_DECIM_DIV,
   output var  logic [3:0]  SYMRATE_EXPONENT,
   output var  logic [8:0]  SYMRATE_MANTISSA,
   output var  logic [23:0] SYMRATE_STEP,
   output var  logic        DC_BLOCK_BYPASS,
   output var  logic [2:0]  MODULATION_SELECT,
   output var  logic        MOD_IS_GFSK,
   output var  logic        MOD_RESERVED,
   output var  logic        RATE_ABOVE_LIMIT,
   output var  logic        BYPASS_MISUSE,
   output var  logic        BASE_WORD_A_UPDATED,
   output var  logic        MODEM_UPDATED,
   output var  logic        UNMAPPED_SEEN
);

   // Storage
   logic [5:0]  base_word_a_high_reg;
   logic [7:0]  base_word_a_mid_reg;
   logic [7:0]  base_word_a_low_reg;
   logic [1:0]  bw_exp_reg;
   logic [1:0]  bw_mant_reg;
   logic [3:0]  rate_exp_reg;
   logic [7:0]  rate_mant_reg;
   logic        dc_bypass_reg;
   logic [2:0]  mod_sel_reg;

   // Bus side
   rfcfg_sel_e  wr_sel;
   rfcfg_sel_e  rd_sel;
   logic [7:0]  rdata_next;
   logic [7:0]  rdata_reg;
   logic        base_word_a_upd_reg;
   logic        modem_upd_reg;
   logic        unmapped_reg;
   logic        unmapped_next;

   // Derived values from the arithmetic block
   logic [8:0]  decim_div;
   logic [23:0] rate_step;
   logic        rate_high;
   logic        misuse_reg;

   // Registered modulation decodes and the field being written
   logic [2:0]  mod_wr;
   logic        gfsk_reg;
   logic        mod_rsv_reg;

   // Address decode, shared by read and write
   function automatic rfcfg_sel_e rfcfg_decode(input rfcfg_addr_t a);
      rfcfg_sel_e s;
      s = RFCFG_SEL_NONE;
      unique case (a)
         `RFCFG_OFS_BASE_WORD_A_HIGH:   s = RFCFG_SEL_FHIGH;
         `RFCFG_OFS_BASE_WORD_A_MID:    s = RFCFG_SEL_FMID;
         `RFCFG_OFS_BASE_WORD_A_LOW:    s = RFCFG_SEL_FLOW;
         `RFCFG_OFS_BW_RATE_EXP: s = RFCFG_SEL_BWEXP;
         `RFCFG_OFS_RATE_MANT:   s = RFCFG_SEL_RMANT;
         `RFCFG_OFS_FORMAT_CTRL: s = RFCFG_SEL_FORMAT;
         default:                s = RFCFG_SEL_NONE;
      endcase
      rfcfg_decode = s;
   endfunction : rfcfg_decode

   // Reserved modulation codes, decoded at reset and on write
   function automatic logic rfcfg_mod_rsv(input logic [2:0] m);
      rfcfg_mod_rsv = (m == RFCFG_MOD_RSV2) || (m == RFCFG_MOD_RSV3);
   endfunction : rfcfg_mod_rsv

   // Strobe qualifies the decode so idle addresses select nothing
   always_comb
   begin
      wr_sel = WR_STB ? rfcfg_decode(ADDR) : RFCFG_SEL_NONE;
      rd_sel = RD_STB ? rfcfg_decode(ADDR) : RFCFG_SEL_NONE;
   end

   // High frequency byte; top two bits are wired, not stored
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         base_word_a_high_reg <= `RFCFG_RST_BASE_WORD_A_HIGH;
      end
      else if (wr_sel == RFCFG_SEL_FHIGH)
      begin
         base_word_a_high_reg <= WDATA[`RFCFG_FLD_BASE_WORD_A_HI_HI:0];
      end
   end

   // Middle frequency byte
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         base_word_a_mid_reg <= `RFCFG_RST_BASE_WORD_A_MID;
      end
      else if (wr_sel == RFCFG_SEL_FMID)
      begin
         base_word_a_mid_reg <= WDATA;
      end
   end

   // Low frequency byte
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         base_word_a_low_reg <= `RFCFG_RST_BASE_WORD_A_LOW;
      end
      else if (wr_sel == RFCFG_SEL_FLOW)
      begin
         base_word_a_low_reg <= WDATA;
      end
   end

   // Bandwidth fields and symbol-rate exponent share one register
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         bw_exp_reg   <= `RFCFG_RST_BW_EXP;
         bw_mant_reg  <= `RFCFG_RST_BW_MANT;
         rate_exp_reg <= `RFCFG_RST_RATE_EXP;
      end
      else if (wr_sel == RFCFG_SEL_BWEXP)
      begin
         bw_exp_reg   <= WDATA[`RFCFG_FLD_BW_EXP_HI:`RFCFG_FLD_BW_EXP_LO];
         bw_mant_reg  <= WDATA[`RFCFG_FLD_BW_MANT_HI:`RFCFG_FLD_BW_MANT_LO];
         rate_exp_reg <= WDATA[`RFCFG_FLD_RATE_EXP_HI:0];
      end
   end

   // Symbol-rate mantissa, low eight bits only
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         rate_mant_reg <= `RFCFG_RST_RATE_MANT;
      end
      else if (wr_sel == RFCFG_SEL_RMANT)
      begin
         rate_mant_reg <= WDATA;
      end
   end

   // Format control: DC-block bypass and modulation select
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         dc_bypass_reg <= `RFCFG_RST_DC_BYPASS;
         mod_sel_reg   <= `RFCFG_RST_MOD_SEL;
      end
      else if (wr_sel == RFCFG_SEL_FORMAT)
      begin
         dc_bypass_reg <= WDATA[`RFCFG_FLD_DC_BYPASS];
         mod_sel_reg   <= WDATA[`RFCFG_FLD_MOD_HI:`RFCFG_FLD_MOD_LO];
      end
   end

   // Modulation code carried by the write data
   always_comb
   begin
      mod_wr = WDATA[`RFCFG_FLD_MOD_HI:`RFCFG_FLD_MOD_LO];
   end

   // Decodes held in flops so the datapath never sees a decode glitch
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         gfsk_reg    <= (`RFCFG_RST_MOD_SEL == RFCFG_MOD_GFSK);
         mod_rsv_reg <= rfcfg_mod_rsv(`RFCFG_RST_MOD_SEL);
      end
      else if (wr_sel == RFCFG_SEL_FORMAT)
      begin
         gfsk_reg    <= (mod_wr == RFCFG_MOD_GFSK);
         mod_rsv_reg <= rfcfg_mod_rsv(mod_wr);
      end
   end

   // Read mux; unused format bits read as zero, wired top frequency bits as 01
   always_comb
   begin
      rdata_next = 8'h00;
      unique case (rd_sel)
         RFCFG_SEL_FHIGH:
         begin
            rdata_next = {`RFCFG_RST_BASE_WORD_A_TOP, base_word_a_high_reg};
         end
         RFCFG_SEL_FMID:
         begin
            rdata_next = base_word_a_mid_reg;
         end
         RFCFG_SEL_FLOW:
         begin
            rdata_next = base_word_a_low_reg;
         end
         RFCFG_SEL_BWEXP:
         begin
            rdata_next = {bw_exp_reg, bw_mant_reg, rate_exp_reg};
         end
         RFCFG_SEL_RMANT:
         begin
            rdata_next = rate_mant_reg;
         end
         RFCFG_SEL_FORMAT:
         begin
            rdata_next = {dc_bypass_reg, mod_sel_reg, 4'h0};
         end
         RFCFG_SEL_NONE:
         begin
            rdata_next = 8'h00;
         end
      endcase
   end

   // Read data stands for one cycle only, zero otherwise
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         rdata_reg <= 8'h00;
      end
      else
      begin
         rdata_reg <= rdata_next;
      end
   end

   // Update pulses let the datapath retune only when needed
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         base_word_a_upd_reg  <= 1'b0;
         modem_upd_reg <= 1'b0;
      end
      else
      begin
         base_word_a_upd_reg  <= (wr_sel == RFCFG_SEL_FHIGH) ||
                          (wr_sel == RFCFG_SEL_FMID) ||
                          (wr_sel == RFCFG_SEL_FLOW);
         modem_upd_reg <= (wr_sel == RFCFG_SEL_BWEXP) ||
                          (wr_sel == RFCFG_SEL_RMANT) ||
                          (wr_sel == RFCFG_SEL_FORMAT);
      end
   end

   // Sticky unmapped-access flag; no clear path, so nothing to race
   always_comb
   begin
      unmapped_next = unmapped_reg;
      if ((WR_STB || RD_STB) && (rfcfg_decode(ADDR) == RFCFG_SEL_NONE))
      begin
         unmapped_next = 1'b1;
      end
   end

   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         unmapped_reg <= 1'b0;
      end
      else
      begin
         unmapped_reg <= unmapped_next;
      end
   end

   // Bandwidth divider and rate step, one cycle behind the fields
   rfcfg_rate_calc #(
      .REF_BASE_WORD_A_HZ (REF_BASE_WORD_A_HZ)
   ) u_rate_calc (
      .clk       (REF_CLK),
      .rst_n     (RST_N),
      .bw_exp    (bw_exp_reg),
      .bw_mant   (bw_mant_reg),
      .rate_exp  (rate_exp_reg),
      .rate_mant (rate_mant_reg),
      .decim_div (decim_div),
      .rate_step (rate_step),
      .rate_high (rate_high)
   );

   // Bypass above the rate limit is allowed but flagged, not blocked
   always_ff @(posedge REF_CLK)
   begin
      if (!RST_N)
      begin
         misuse_reg <= 1'b0;
      end
      else
      begin
         misuse_reg <= dc_bypass_reg && rate_high;
      end
   end

   // Frequency word: fixed top bits over the three bytes
   assign BASE_WORD_A = {`RFCFG_RST_BASE_WORD_A_TOP, base_word_a_high_reg,
                         base_word_a_mid_reg, base_word_a_low_reg};

   // Modem settings from their storage; divider and step from the arithmetic block
   assign BW_EXPONENT      = bw_exp_reg;
   assign BW_MANTISSA      = bw_mant_reg;
   assign BW_DECIM_DIV     = decim_div;
   assign SYMRATE_EXPONENT = rate_exp_reg;
   assign SYMRATE_MANTISSA = {1'b1, rate_mant_reg};
   assign SYMRATE_STEP     = rate_step;
   assign DC_BLOCK_BYPASS  = dc_bypass_reg;

   // Modulation decode; reserved codes pass through but are flagged
   assign MODULATION_SELECT = mod_sel_reg;
   assign MOD_IS_GFSK       = gfsk_reg;
   assign MOD_RESERVED      = mod_rsv_reg;

   // Status and bus outputs
   assign RATE_ABOVE_LIMIT = rate_high;
   assign BYPASS_MISUSE    = misuse_reg;
   assign BASE_WORD_A_UPDATED     = base_word_a_upd_reg;
   assign MODEM_UPDATED    = modem_upd_reg;
   assign UNMAPPED_SEEN    = unmapped_reg;
   assign RDATA            = rdata_reg;

endmodule : rfcfg_regs
`default_nettype wire

/* verilog/rfcfg_dummy_never.sv */
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

/* testbench/rfcfg_regs_props.sv */
`timescale 1ns/10ps
`default_nettype none
module rfcfg_regs_props
(
   input wire logic        REF_CLK,
   input wire logic        RST_N,
   input wire logic [15:0] ADDR,
   input wire logic [7:0]  WDATA,
   input wire logic        WR_STB,
   input wire logic        RD_STB,
   input wire logic [7:0]  RDATA,
   input wire logic [23:0] BASE_WORD_A,
   input wire logic [1:0]  BW_EXPONENT,
   input wire logic [1:0]  BW_MANTISSA,
   input wire logic [8:0]  BW_DECIM_DIV,
   input wire logic [3:0]  SYMRATE_EXPONENT,
   input wire logic [8:0]  SYMRATE_MANTISSA,
   input wire logic [23:0] SYMRATE_STEP,
   input wire logic        DC_BLOCK_BYPASS,
   input wire logic [2:0]  MODULATION_SELECT,
   input wire logic        MOD_IS_GFSK,
   input wire logic        BASE_WORD_A_UPDATED,
   input wire logic        MOD_RESERVED,
   input wire logic        RATE_ABOVE_LIMIT,
   input wire logic        BYPASS_MISUSE,
   input wire logic        MODEM_UPDATED,
   input wire logic        UNMAPPED_SEEN
);
   // One clock domain, so one default clocking and disable
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // Read data stands only in the cycle after a read strobe
   chk_rdata_idle: assert property (!RD_STB |=> RDATA == 8'h00)
      else $error("read data not zero outside read cycle");
   chk_top_fixed: assert property (BASE_WORD_A[23:22] == 2'h1)
      else $error("top frequency bits not fixed");
   chk_high_write: assert property (WR_STB && ADDR == 16'hdf09
      |=> BASE_WORD_A[21:16] == $past(WDATA[5:0]))
      else $error("high frequency byte not stored");
   chk_mid_write: assert property (WR_STB && ADDR == 16'hdf0a
      |=> BASE_WORD_A[15:8] == $past(WDATA))
      else $error("middle frequency byte not stored");
   chk_low_write: assert property (WR_STB && ADDR == 16'hdf0b
      |=> BASE_WORD_A[7:0] == $past(WDATA))
      else $error("low frequency byte not stored");
   chk_base_word_a_pulse: assert property (WR_STB && ADDR >= 16'hdf09
      && ADDR <= 16'hdf0b |=> BASE_WORD_A_UPDATED)
      else $error("frequency update pulse missing");
   // Derived values lag their fields by one cycle
   chk_decim_calc: assert property ($past(RST_N) |-> BW_DECIM_DIV ==
      (({4'h0, $past(BW_MANTISSA), 3'h0} + 9'h020)
      << $past(BW_EXPONENT)))
      else $error("decimation divider wrong");
   chk_step_calc: assert property ($past(RST_N) |-> SYMRATE_STEP ==
      ({15'h0, $past(SYMRATE_MANTISSA)} << $past(SYMRATE_EXPONENT)))
      else $error("symbol rate step wrong");
   chk_mant_write: assert property (WR_STB && ADDR == 16'hdf0d
      |=> SYMRATE_MANTISSA == {1'b1, $past(WDATA)})
      else $error("rate mantissa not stored with hidden one");
   chk_modem_pulse: assert property (WR_STB && ADDR >= 16'hdf0c
      && ADDR <= 16'hdf0e |=> MODEM_UPDATED)
      else $error("modem update pulse missing");
   chk_misuse_flag: assert property ($past(RST_N) |-> BYPASS_MISUSE ==
      ($past(DC_BLOCK_BYPASS) && $past(RATE_ABOVE_LIMIT)))
      else $error("bypass misuse flag wrong");
   chk_unmapped_sticky: assert property (UNMAPPED_SEEN |=> UNMAPPED_SEEN)
      else $error("unmapped flag cleared without reset");
   chk_rsv_decode: assert property (MOD_RESERVED ==
      (MODULATION_SELECT == 3'h2 || MODULATION_SELECT == 3'h3))
      else $error("reserved modulation decode wrong");
   chk_format_write: assert property (WR_STB && ADDR == 16'hdf0e
      |=> DC_BLOCK_BYPASS == $past(WDATA[7])
      && MODULATION_SELECT == $past(WDATA[6:4]))
      else $error("format control not stored");
   chk_gfsk_decode: assert property (MOD_IS_GFSK ==
      (MODULATION_SELECT == 3'h1))
      else $error("gfsk decode wrong");
endmodule : rfcfg_regs_props

bind rfcfg_regs rfcfg_regs_props u_props (
   .REF_CLK           (REF_CLK),
   .RST_N             (RST_N),
   .ADDR              (ADDR),
   .WDATA             (WDATA),
   .WR_STB            (WR_STB),
   .RD_STB            (RD_STB),
   .RDATA             (RDATA),
   .BASE_WORD_A       (BASE_WORD_A),
   .BW_EXPONENT       (BW_EXPONENT),
   .BW_MANTISSA       (BW_MANTISSA),
   .BW_DECIM_DIV      (BW_DECIM_DIV),
   .SYMRATE_EXPONENT  (SYMRATE_EXPONENT),
   .SYMRATE_MANTISSA  (SYMRATE_MANTISSA),
   .SYMRATE_STEP      (SYMRATE_STEP),
   .DC_BLOCK_BYPASS   (DC_BLOCK_BYPASS),
   .MODULATION_SELECT (MODULATION_SELECT),
   .MOD_IS_GFSK       (MOD_IS_GFSK),
   .BASE_WORD_A_UPDATED      (BASE_WORD_A_UPDATED),
   .MOD_RESERVED      (MOD_RESERVED),
   .RATE_ABOVE_LIMIT  (RATE_ABOVE_LIMIT),
   .BYPASS_MISUSE     (BYPASS_MISUSE),
   .MODEM_UPDATED     (MODEM_UPDATED),
   .UNMAPPED_SEEN     (UNMAPPED_SEEN)
);
`default_nettype wire

/* testbench/rfcfg_regs_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module rfcfg_regs_tb;
   logic        REF_CLK;
   logic        RST_N  = 1'b0;
   logic [15:0] ADDR   = 16'h0000;
   logic [7:0]  WDATA  = 8'h00;
   logic        WR_STB = 1'b0;
   logic        RD_STB = 1'b0;
   logic [7:0]  RDATA;
   logic [23:0] BASE_WORD_A, SYMRATE_STEP;
   logic [1:0]  BW_EXPONENT, BW_MANTISSA;
   logic [8:0]  BW_DECIM_DIV, SYMRATE_MANTISSA;
   logic [3:0]  SYMRATE_EXPONENT;
   logic [2:0]  MODULATION_SELECT;
   logic        DC_BLOCK_BYPASS, MOD_IS_GFSK, MOD_RESERVED;
   logic        RATE_ABOVE_LIMIT, BYPASS_MISUSE, BASE_WORD_A_UPDATED;
   logic        MODEM_UPDATED, UNMAPPED_SEEN;
   int          error_cnt = 0;
   int          checks    = 0;
   // Read-back values after reset, lowest address first
   logic [7:0]  rst_tab [6] = '{8'h5e, 8'hc4, 8'hec, 8'h8c, 8'h22, 8'h00};

   rfcfg_regs uut (
      .REF_CLK           (REF_CLK),
      .RST_N             (RST_N),
      .ADDR              (ADDR),
      .WDATA             (WDATA),
      .WR_STB            (WR_STB),
      .RD_STB            (RD_STB),
      .RDATA             (RDATA),
      .BASE_WORD_A       (BASE_WORD_A),
      .BW_EXPONENT       (BW_EXPONENT),
      .BW_MANTISSA       (BW_MANTISSA),
      .BW_DECIM_DIV      (BW_DECIM_DIV),
      .SYMRATE_EXPONENT  (SYMRATE_EXPONENT),
      .SYMRATE_MANTISSA  (SYMRATE_MANTISSA),
      .SYMRATE_STEP      (SYMRATE_STEP),
      .DC_BLOCK_BYPASS   (DC_BLOCK_BYPASS),
      .MODULATION_SELECT (MODULATION_SELECT),
      .MOD_IS_GFSK       (MOD_IS_GFSK),
      .MOD_RESERVED      (MOD_RESERVED),
      .RATE_ABOVE_LIMIT  (RATE_ABOVE_LIMIT),
      .BYPASS_MISUSE     (BYPASS_MISUSE),
      .BASE_WORD_A_UPDATED      (BASE_WORD_A_UPDATED),
      .MODEM_UPDATED     (MODEM_UPDATED),
      .UNMAPPED_SEEN     (UNMAPPED_SEEN)
   );

   // 50 MHz reference clock
   initial
   begin
      REF_CLK = 1'b0;
      forever #10 REF_CLK = ~REF_CLK;
   end

   task chk(input logic [23:0] seen, input logic [23:0] exp);
      checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task report_and_stop;
      $display("checks=%0d error_cnt=%0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : report_and_stop

   // Returns inside the cycle where the new field shows
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge REF_CLK);
      WR_STB <= 1'b1;
      ADDR   <= a;
      WDATA  <= d;
      @(posedge REF_CLK);
      WR_STB <= 1'b0;
      #1;
   endtask : wr

   // Data looked at in the one cycle it stands, then checked zero a cycle later
   task rd(input logic [15:0] a, input logic [7:0] exp);
      @(posedge REF_CLK);
      RD_STB <= 1'b1;
      ADDR   <= a;
      @(posedge REF_CLK);
      RD_STB <= 1'b0;
      #1;
      chk(RDATA, exp);
      @(posedge REF_CLK);
      #1;
      chk(RDATA, 8'h00);
   endtask : rd

   task tick(input int n);
      repeat (n) @(posedge REF_CLK);
      #1;
   endtask : tick

   // Whole run is about 150 cycles, far under this 10000-cycle limit
   initial
   begin
      #200000;
      error_cnt++;
      report_and_stop;
   end

   initial
   begin
      repeat (12) @(posedge REF_CLK);
      RST_N <= 1'b1;
      tick(1);
      chk(BASE_WORD_A, 24'h5ec4ec);
      chk(BW_DECIM_DIV, 9'h080);
      chk(SYMRATE_MANTISSA, 9'h122);
      chk(SYMRATE_STEP, 24'h122000);
      chk(RATE_ABOVE_LIMIT, 1'b1);
      for (int i = 0; i < 6; i++)
         rd(16'(16'hdf09 + i), rst_tab[i]);
      // Top two bits must ignore the write
      wr(16'hdf09, 8'hff);
      wr(16'hdf0a, 8'h00);
      wr(16'hdf0b, 8'h01);
      chk(BASE_WORD_A_UPDATED, 1'b1);
      chk(BASE_WORD_A, 24'h7f0001);
      rd(16'hdf09, 8'h7f);
      // Largest bandwidth divisor, small symbol rate
      wr(16'hdf0c, 8'hf3);
      chk(MODEM_UPDATED, 1'b1);
      wr(16'hdf0d, 8'hff);
      tick(1);
      chk({BW_EXPONENT, BW_MANTISSA}, 4'hf);
      chk(BW_DECIM_DIV, 9'h1c0);
      chk(SYMRATE_EXPONENT, 4'h3);
      chk(SYMRATE_STEP, 24'h000ff8);
      chk(RATE_ABOVE_LIMIT, 1'b0);
      rd(16'hdf0d, 8'hff);
      // Every modulation code with and without bypass
      for (int i = 0; i < 16; i++)
      begin
         wr(16'hdf0e, {i[3:0], 4'hf});
         chk(DC_BLOCK_BYPASS, i[3]);
         chk(MODULATION_SELECT, i[2:0]);
         chk(MOD_IS_GFSK, i[2:0] == 3'h1);
         chk(MOD_RESERVED, i[2:0] == 3'h2 || i[2:0] == 3'h3);
         rd(16'hdf0e, {i[3:0], 4'h0});
      end
      chk(BYPASS_MISUSE, 1'b0);
      // Bypass at the fast default rate is flagged
      wr(16'hdf0c, 8'h8c);
      wr(16'hdf0d, 8'h22);
      wr(16'hdf0e, 8'h80);
      tick(2);
      chk(RATE_ABOVE_LIMIT, 1'b1);
      chk(BYPASS_MISUSE, 1'b1);
      // Unmapped places set the sticky flag and leave the frequency word alone
      chk(UNMAPPED_SEEN, 1'b0);
      wr(16'hdf08, 8'h55);
      chk(UNMAPPED_SEEN, 1'b1);
      chk(BASE_WORD_A, 24'h7f0001);
      rd(16'hdf0f, 8'h00);
      // Second reset in mid-run restores every field and flag
      @(posedge REF_CLK);
      RST_N <= 1'b0;
      repeat (2) @(posedge REF_CLK);
      RST_N <= 1'b1;
      tick(1);
      chk(BASE_WORD_A, 24'h5ec4ec);
      chk(BW_DECIM_DIV, 9'h080);
      chk(SYMRATE_STEP, 24'h122000);
      chk(DC_BLOCK_BYPASS, 1'b0);
      chk(MOD_IS_GFSK, 1'b0);
      chk(BYPASS_MISUSE, 1'b0);
      chk(UNMAPPED_SEEN, 1'b0);
      rd(16'hdf0e, 8'h00);
      report_and_stop;
   end
endmodule : rfcfg_regs_tb
`default_nettype wire
